//--- common/xiob_map.vh
// Address map, field layout and constants of the extended I/O port block.
// Assumes a 32-bit classic Wishbone slave with byte addresses and word-aligned registers.
`ifndef XIOB_MAP_VH
`define XIOB_MAP_VH

// Register byte offsets
`define XIOB_ADR_DIR 8'h00
`define XIOB_ADR_MAIN 8'h04
`define XIOB_ADR_EXT_A 8'h08
`define XIOB_ADR_EXT_B 8'h0c
`define XIOB_ADR_EXT_C 8'h10
`define XIOB_ADR_POINT 8'h14
`define XIOB_ADR_PT_READ 8'h18
`define XIOB_ADR_BLK_READ 8'h1c
`define XIOB_ADR_SAVE 8'h20

// Reset values
`define XIOB_DIR_RST 5'h00
`define XIOB_OUT_RST 48'h0000_0000_0000
`define XIOB_ZERO32 32'h0000_0000

// Point command fields
`define XIOB_PT_HI 5
`define XIOB_PT_LO 0
`define XIOB_OP_HI 9
`define XIOB_OP_LO 8
`define XIOB_VAL_HI 31
`define XIOB_VAL_LO 16
`define XIOB_OP_CLEAR 2'h0
`define XIOB_OP_SET 2'h1
`define XIOB_OP_COND 2'h2

// Point numbering
`define XIOB_PT_MAIN_FIRST 6'h01
`define XIOB_PT_MAIN_LAST 6'h08
`define XIOB_PT_EXT_FIRST 6'h11
`define XIOB_PT_EXT_LAST 6'h38
`define XIOB_MAIN_BIAS 6'h01
`define XIOB_EXT_BIAS 6'h09

// Block numbers for block read
`define XIOB_BLK_MAIN 3'h0
`define XIOB_BLK_2 3'h2
`define XIOB_BLK_3 3'h3
`define XIOB_BLK_4 3'h4
`define XIOB_BLK_5 3'h5
`define XIOB_BLK_6 3'h6
`define XIOB_BLK_SEL_HI 10
`define XIOB_BLK_SEL_LO 8

// Marker that says the store holds a saved image (value is arbitrary)
`define XIOB_NVM_SIG 16'ha5c3

`endif

//--- design/xiob_point_dec.v
// Decodes a point number into an index of the 48-bit point vector {ext 17-56, main 1-8}.
// Assumes a 6-bit point number; anything outside 1-8 and 17-56 is flagged invalid.
`include "xiob_map.vh"
`timescale 1ns/100ps
`default_nettype none

module xiob_point_dec (
	input wire [5:0] i_point,
	output reg o_valid,
	output reg [5:0] o_idx
);

	// Main points map to 0-7, extended points 17-56 map to 8-47
	always @* begin
		o_valid = 1'b0;
		o_idx = 6'h00;
		if (i_point >= `XIOB_PT_MAIN_FIRST && i_point <= `XIOB_PT_MAIN_LAST) begin
			o_valid = 1'b1;
			o_idx = i_point - `XIOB_MAIN_BIAS;
		end else if (i_point >= `XIOB_PT_EXT_FIRST && i_point <= `XIOB_PT_EXT_LAST) begin
			o_valid = 1'b1;
			o_idx = i_point - `XIOB_EXT_BIAS;
		end
	end

endmodule // xiob_point_dec
`default_nettype wire

//--- design/xiob_nvm.v
// Non-volatile image of block directions and output states.
// Assumes the storage survives i_reset; only the signature decides whether an image exists.
`include "xiob_map.vh"
`timescale 1ns/100ps
`default_nettype none

module xiob_nvm (
	input wire i_clk,
	input wire i_save,
	input wire [4:0] i_dir,
	input wire [47:0] i_out,
	output wire o_valid,
	output wire [4:0] o_dir,
	output wire [47:0] o_out
);

	// Contents deliberately have no reset: they model memory that outlives a reset
	reg [15:0] sig;
	reg [4:0] dir_img;
	reg [47:0] out_img;

	// Snapshot taken in one cycle on a save strobe
	always @(posedge i_clk) begin
		if (i_save) begin
			sig <= `XIOB_NVM_SIG;
			dir_img <= i_dir;
			out_img <= i_out;
		end
	end

	assign o_valid = (sig == `XIOB_NVM_SIG);
	assign o_dir = dir_img;
	assign o_out = out_img;

endmodule // xiob_nvm
`default_nettype wire

//--- design/xiob_port.v
// Extended I/O port: eight main outputs plus forty extended points in five blocks.
// Assumes a classic Wishbone master on the register side and external switches,
// relays or I/O racks on the extended pins, which are split into in, out and enable.
`include "xiob_map.vh"
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Forty extended points numbered 17 to 56 form blocks 2 to 6, direction chosen per block only.
// - Each block has one direction bit, one meaning output and zero meaning input.
// - Direction bit 0 steers block 2 and bits 1 to 4 steer blocks 3 to 6.
// - Without a saved image the direction word starts at zero, all blocks inputs.
// - A save request stores the direction word and all output states in non-volatile memory.
// - Any single point 1-8, or 17-56 in a driving block, can be set or cleared without touching the others.
// - A conditional point write drives the point high when the supplied value is nonzero.
// - The first bulk write value is the eight-bit main port, bit 0 driving output 1.
// - Further bulk values carry sixteen points each, 17-32 and 33-48, then eight points 49-56.
// - Bulk write bits that land on input points are discarded.
// - A main port write alone updates all eight main outputs and leaves other blocks alone.
// - A block read returns eight bits of block 0 or of blocks 2 to 6.
// - A point read returns the level of point 1-8 or 17-56, point 17 being bit 0 of block 2.
module xiob_port (
	input wire i_clk,
	input wire i_reset,
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire [7:0] i_wb_adr,
	input wire [3:0] i_wb_sel,
	input wire [31:0] i_wb_dat,
	output reg [31:0] o_wb_dat,
	output reg o_wb_ack,
	input wire [7:0] i_main_in,
	output wire [7:0] o_main_out,
	input wire [39:0] i_ext_in,
	output wire [39:0] o_ext_out,
	output wire [39:0] o_ext_oe_n
);

	// Register map, byte offsets on the 32-bit bus:
	// 0x00 direction word, bit 0 block 2 up to bit 4 block 6
	// 0x04 main outputs 1-8, the first bulk value
	// 0x08 points 17-32, 0x0c points 33-48, 0x10 points 49-56
	// 0x14 point command: number, operation, value of the conditional write
	// 0x18 point query: select on write, level and selection on read
	// 0x1c block query: select on write, byte and selection on read
	// 0x20 save strobe on write, image flag on read
	// Bulk registers read back the latch, not the pins
	// The rack on block 5 is not guarded here; software keeps that block an input

	// State: block directions and the output latch of all 48 points
	reg [4:0] dir;
	reg [47:0] out_all;
	reg [5:0] pt_sel;
	reg [2:0] blk_sel;
	reg [47:0] next_out_all;
	reg [4:0] next_dir;
	reg [31:0] next_rdat;
	reg [7:0] blk_data;

	wire fire;
	wire wr_fire;
	wire [31:0] lane;
	wire [47:0] drive_mask;
	wire [39:0] ext_lvl;
	wire [47:0] lvl_all;
	wire save_pulse;
	wire nvm_valid;
	wire [4:0] nvm_dir;
	wire [47:0] nvm_out;
	wire cmd_valid;
	wire [5:0] cmd_idx;
	wire rd_valid;
	wire [5:0] rd_idx;
	wire [1:0] cmd_op;
	wire wr_dir;
	wire wr_pt_sel;
	wire wr_blk_sel;
	wire rd_fire;
	wire cmd_level;
	wire cmd_all_lanes;
	wire [15:0] ext_a_take;
	wire [15:0] ext_b_take;
	wire [7:0] ext_c_take;

	// A request is taken once; ack drops in the cycle after it was given.
	// Gating on ack keeps a master that holds stb through the ack edge from
	// being answered twice, at the price of one idle cycle between requests.
	assign fire = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	assign wr_fire = fire & i_wb_we;
	assign lane = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
	assign cmd_op = i_wb_dat[`XIOB_OP_HI:`XIOB_OP_LO];

	// Per-register strobes; the small registers only need byte lane 0
	assign wr_dir = wr_fire && (i_wb_adr == `XIOB_ADR_DIR) && i_wb_sel[0];
	assign wr_pt_sel = wr_fire && (i_wb_adr == `XIOB_ADR_PT_READ) && i_wb_sel[0];
	assign wr_blk_sel = wr_fire && (i_wb_adr == `XIOB_ADR_BLK_READ) && i_wb_sel[0];
	assign rd_fire = fire & ~i_wb_we;

	// A point command touches one bit, so a partial word is ignored as a whole
	assign cmd_level = |i_wb_dat[`XIOB_VAL_HI:`XIOB_VAL_LO];
	assign cmd_all_lanes = &i_wb_sel;

	// Main outputs always drive; every extended byte follows its own direction bit
	assign drive_mask[7:0] = 8'hff;
	genvar b;
	generate
		for (b = 0; b < 5; b = b + 1) begin : g_blk
			assign drive_mask[8 * b + 15:8 * b + 8] = {8{dir[b]}};
			assign o_ext_oe_n[8 * b + 7:8 * b] = {8{~dir[b]}};
			assign ext_lvl[8 * b + 7:8 * b] = dir[b] ? out_all[8 * b + 15:8 * b + 8] :
				i_ext_in[8 * b + 7:8 * b];
		end
	endgenerate

	// Bulk bits that may land: lane enabled and block driving, others keep the latch
	assign ext_a_take = lane[15:0] & drive_mask[23:8];
	assign ext_b_take = lane[15:0] & drive_mask[39:24];
	assign ext_c_take = lane[7:0] & drive_mask[47:40];

	assign o_main_out = out_all[7:0];
	assign o_ext_out = out_all[47:8];
	// Point 1-8 reads the main input pins; 17-56 read the pin or the driven level
	assign lvl_all = {ext_lvl, i_main_in};
	assign save_pulse = wr_fire && (i_wb_adr == `XIOB_ADR_SAVE) && i_wb_sel[0];

	// Decoder for a point named in a set, clear or conditional command
	xiob_point_dec u_cmd_dec (
		.i_point(i_wb_dat[`XIOB_PT_HI:`XIOB_PT_LO]),
		.o_valid(cmd_valid),
		.o_idx(cmd_idx)
	);

	// Decoder for the point selected for reading
	xiob_point_dec u_rd_dec (
		.i_point(pt_sel),
		.o_valid(rd_valid),
		.o_idx(rd_idx)
	);

	// Saved image of directions and outputs
	xiob_nvm u_nvm (
		.i_clk(i_clk),
		.i_save(save_pulse),
		.i_dir(dir),
		.i_out(out_all),
		.o_valid(nvm_valid),
		.o_dir(nvm_dir),
		.o_out(nvm_out)
	);

	// Block read selects one byte; unlisted block numbers read as zero
	always @* begin
		case (blk_sel)
			`XIOB_BLK_MAIN: blk_data = i_main_in;
			`XIOB_BLK_2: blk_data = ext_lvl[7:0];
			`XIOB_BLK_3: blk_data = ext_lvl[15:8];
			`XIOB_BLK_4: blk_data = ext_lvl[23:16];
			`XIOB_BLK_5: blk_data = ext_lvl[31:24];
			`XIOB_BLK_6: blk_data = ext_lvl[39:32];
			default: blk_data = 8'h00;
		endcase
	end

	// Direction word takes byte lane 0 only; the rack on block 5 is left to software
	always @* begin
		next_dir = dir;
		if (wr_dir) begin
			next_dir = i_wb_dat[4:0];
		end
	end

	// Output latch updates; bits of input blocks keep their old value
	always @* begin
		next_out_all = out_all;
		if (wr_fire) begin
			case (i_wb_adr)
				`XIOB_ADR_MAIN: begin
					// Whole main byte replaced, other blocks untouched
					next_out_all[7:0] = (out_all[7:0] & ~lane[7:0]) | (i_wb_dat[7:0] & lane[7:0]);
				end
				`XIOB_ADR_EXT_A: begin
					next_out_all[23:8] = (out_all[23:8] & ~ext_a_take) |
						(i_wb_dat[15:0] & ext_a_take);
				end
				`XIOB_ADR_EXT_B: begin
					next_out_all[39:24] = (out_all[39:24] & ~ext_b_take) |
						(i_wb_dat[15:0] & ext_b_take);
				end
				`XIOB_ADR_EXT_C: begin
					// Only points 49-56 exist; upper value bits have no points
					next_out_all[47:40] = (out_all[47:40] & ~ext_c_take) |
						(i_wb_dat[7:0] & ext_c_take);
				end
				`XIOB_ADR_POINT: begin
					// One bit changes; invalid points and input blocks are ignored
					if (cmd_valid && drive_mask[cmd_idx] && cmd_all_lanes) begin
						case (cmd_op)
							`XIOB_OP_SET: next_out_all[cmd_idx] = 1'b1;
							`XIOB_OP_CLEAR: next_out_all[cmd_idx] = 1'b0;
							`XIOB_OP_COND: next_out_all[cmd_idx] = cmd_level;
							default: next_out_all[cmd_idx] = out_all[cmd_idx];
						endcase
					end
				end
				default: next_out_all = out_all;
			endcase
		end
	end

	// Read data mux; unmapped offsets read zero
	always @* begin
		next_rdat = `XIOB_ZERO32;
		case (i_wb_adr)
			`XIOB_ADR_DIR: next_rdat[4:0] = dir;
			`XIOB_ADR_MAIN: next_rdat[7:0] = out_all[7:0];
			`XIOB_ADR_EXT_A: next_rdat[15:0] = out_all[23:8];
			`XIOB_ADR_EXT_B: next_rdat[15:0] = out_all[39:24];
			`XIOB_ADR_EXT_C: next_rdat[7:0] = out_all[47:40];
			`XIOB_ADR_PT_READ: begin
				next_rdat[0] = rd_valid & lvl_all[rd_idx];
				next_rdat[`XIOB_PT_HI + 8:`XIOB_PT_LO + 8] = pt_sel;
			end
			`XIOB_ADR_BLK_READ: begin
				next_rdat[7:0] = blk_data;
				next_rdat[`XIOB_BLK_SEL_HI:`XIOB_BLK_SEL_LO] = blk_sel;
			end
			`XIOB_ADR_SAVE: next_rdat[0] = nvm_valid;
			default: next_rdat = `XIOB_ZERO32;
		endcase
	end

	// Reset restores a saved image, else all blocks start as inputs with outputs low
	always @(posedge i_clk) begin
		if (i_reset) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= `XIOB_ZERO32;
			pt_sel <= 6'h00;
			blk_sel <= 3'h0;
			// A saved image outranks the defaults, so a save outlives every reset
			if (nvm_valid) begin
				dir <= nvm_dir;
				out_all <= nvm_out;
			end else begin
				dir <= `XIOB_DIR_RST;
				out_all <= `XIOB_OUT_RST;
			end
		end else begin
			o_wb_ack <= fire;
			// Read data is held after ack, so a late look still sees the last answer
			if (rd_fire) begin
				o_wb_dat <= next_rdat;
			end
			dir <= next_dir;
			out_all <= next_out_all;
			// Query selections stay until rewritten, so a read can be repeated
			if (wr_pt_sel) begin
				pt_sel <= i_wb_dat[`XIOB_PT_HI:`XIOB_PT_LO];
			end
			if (wr_blk_sel) begin
				blk_sel <= i_wb_dat[2:0];
			end
		end
	end

endmodule // xiob_port
`default_nettype wire

//--- bench/xiob_pin_model.sv
// Switches and relays on the extended pins, with an optional I/O rack.
// Assumes the bench sets switch levels and whether a rack is fitted.
`timescale 1ns/100ps
`default_nettype none
module xiob_pin_model (
	input wire logic i_rack,
	input wire logic [39:0] i_sw,
	input wire logic [39:0] i_out,
	input wire logic [39:0] i_oe_n,
	output logic [39:0] o_pin
);
	// Driven points show the latch, others the switch; the rack grounds block 5
	always_comb begin
		o_pin = (i_out & ~i_oe_n) | (i_sw & i_oe_n);
		if (i_rack)
			o_pin[31:24] = 8'h00;
	end
endmodule // xiob_pin_model
`default_nettype wire

//--- bench/xiob_port_assertions.sv
// Checker for the extended I/O port, watching its top ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module xiob_port_assertions (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic o_wb_ack,
	input wire logic [7:0] o_main_out,
	input wire logic [39:0] o_ext_out,
	input wire logic [39:0] o_ext_oe_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// Taken writes; a point command needs every lane
	wire logic wr = i_wb_cyc & i_wb_stb & !o_wb_ack & i_wb_we & i_wb_sel[0];
	wire logic pw = wr && i_wb_adr == 8'h14 && &i_wb_sel && i_wb_dat[5:0] inside {[1:8]};
	wire logic [4:0] b = {o_ext_oe_n[32], o_ext_oe_n[24], o_ext_oe_n[16], o_ext_oe_n[8], o_ext_oe_n[0]};
	wire logic [39:0] bx = {{8{b[4]}}, {8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
	property p_blk; o_ext_oe_n == bx; endproperty
	a_blk: assert property (p_blk) else $error("block lanes split");
	property p_dir; wr && i_wb_adr == 8'h00 |=> b == ~$past(i_wb_dat[4:0]); endproperty
	a_dir: assert property (p_dir) else $error("direction map");
	property p_mw; wr && i_wb_adr == 8'h04 |=> o_main_out == $past(i_wb_dat[7:0]); endproperty
	a_mw: assert property (p_mw) else $error("main write");
	property p_alone; wr && i_wb_adr == 8'h04 |=> $stable(o_ext_out); endproperty
	a_alone: assert property (p_alone) else $error("main write moved ext");
	property p_take; wr && i_wb_adr == 8'h08 |=>
		((o_ext_out[15:0] ^ $past(i_wb_dat[15:0])) & ~o_ext_oe_n[15:0]) == 16'h0000; endproperty
	a_take: assert property (p_take) else $error("ext write");
	property p_keep; wr && i_wb_adr == 8'h0c |=>
		((o_ext_out[31:16] ^ $past(o_ext_out[31:16])) & o_ext_oe_n[31:16]) == 16'h0000; endproperty
	a_keep: assert property (p_keep) else $error("input bit written");
	property p_set; pw && i_wb_dat[9:8] == 2'h1 |=>
		o_main_out == ($past(o_main_out) | (8'h01 << ($past(i_wb_dat[5:0]) - 6'h01))); endproperty
	a_set: assert property (p_set) else $error("point set");
	property p_cond; pw && i_wb_dat[9:8] == 2'h2 |=>
		o_main_out[$past(i_wb_dat[2:0]) - 3'h1] == |$past(i_wb_dat[31:16]); endproperty
	a_cond: assert property (p_cond) else $error("conditional write");
endmodule // xiob_port_assertions
`default_nettype wire

//--- bench/testbench.sv
// Random and corner traffic for the extended I/O port over classic Wishbone.
// Assumes the pin model and checker files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic i_clk = 1'b0, i_reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, lv;
	logic [7:0] adr = 8'h00, mi = 8'h00, mo, em, sm;
	logic [31:0] wd = 32'h0000_0000, rdat, rd, q;
	logic [39:0] sw = 40'h00_0000_0000, pin, eo, oe, ee, se, w;
	logic [15:0] lf = 16'h6e8f;
	logic [4:0] ed, sd;
	logic [5:0] pt;
	logic [2:0] b;
	int error_cnt = 0, compares = 0, ticks = 0;
	xiob_port u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wd), .o_wb_dat(rdat), .o_wb_ack(ack), .i_main_in(mi),
		.o_main_out(mo), .i_ext_in(pin), .o_ext_out(eo), .o_ext_oe_n(oe));
	xiob_pin_model u_pins (.i_rack(1'b1), .i_sw(sw), .i_out(eo), .i_oe_n(oe), .o_pin(pin));
	// Clock, and a guard that cuts a hang short
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		ticks <= ticks + 1;
		if (ticks == 8000) begin
			error_cnt++;
			complete_run();
		end
	end
	// Fixed-seed LFSR step
	function automatic logic [15:0] r();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction
	// Enable lanes expected from a direction word
	function automatic logic [39:0] ox(input logic [4:0] d);
		for (int k = 0; k < 5; k++)
			ox[k*8 +: 8] = {8{~d[k]}};
	endfunction
	// One bus cycle, held until ack is seen at an edge
	task automatic wb(input logic x, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		{cyc, stb, we, adr, wd} <= {2'b11, x, a, d};
		@(posedge i_clk);
		while (ack !== 1'b1)
			@(posedge i_clk);
		rd = rdat;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic complete_run();
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence; block 5 stays input because the rack grounds it
	initial begin
		repeat (8) @(posedge i_clk);
		i_reset <= 1'b0;
		{em, ee} = 48'h0000_0000_0000;
		wb(1'b0, 8'h00, 32'h0000_0000);
		chk({rd[4:0], oe}, {5'h00, ox(5'h00)});
		for (int i = 0; i < 60; i++) begin
			q = {r(), r()};
			ed = ((i < 5) ? 5'h01 << i : q[4:0]) & 5'h17;
			wb(1'b1, 8'h00, {27'h0, ed});
			chk(oe, ox(ed));
			wb(1'b0, 8'h00, 32'h0000_0000);
			chk(rd, {27'h0, ed});
			{mi, sw} <= {q, q[31:16]};
			q = (i == 0) ? 32'h0000_0007 : {r(), r()};
			em = q[7:0];
			wb(1'b1, 8'h04, q);
			chk({mo, eo}, {em, ee});
			wb(1'b0, 8'h04, 32'h0000_0000);
			chk(rd, {24'h0, em});
			for (logic [7:0] j = 0; j < 3; j++) begin
				q = {r(), r()};
				w = (((j == 2) ? 40'hff : 40'hffff) << (16 * j)) & ~ox(ed);
				ee = (ee & ~w) | (({24'h0, q[15:0]} << (16 * j)) & w);
				wb(1'b1, 8'h08 + (j << 2), q);
				chk(eo, ee);
				wb(1'b0, 8'h08 + (j << 2), 32'h0000_0000);
				chk(rd, (ee >> (16 * j)) & ((j == 2) ? 40'hff : 40'hffff));
			end
			q = {r(), r()};
			pt = q[16] ? 6'h01 + q[2:0] : 6'h11 + 6'(q[7:0] % 40);
			if (q[20])
				q[31:16] = 16'h0000;
			lv = (q[9:8] == 2'h1) | ((q[9:8] == 2'h2) & (|q[31:16]));
			if (q[9:8] != 2'h3 && pt < 6'h09)
				em[pt - 6'h01] = lv;
			else if (q[9:8] != 2'h3 && ed[(pt - 6'h11) >> 3])
				ee[pt - 6'h11] = lv;
			wb(1'b1, 8'h14, {q[31:16], 6'h00, q[9:8], 2'h0, pt});
			chk({mo, eo}, {em, ee});
			w = (ee & ~ox(ed)) | (sw & ox(ed) & 40'hff_00ff_ffff);
			wb(1'b1, 8'h18, {26'h0, pt});
			wb(1'b0, 8'h18, 32'h0000_0000);
			lv = (pt < 6'h09) ? mi[pt - 6'h01] : w[pt - 6'h11];
			chk({rd[13:8], rd[0]}, {pt, lv});
			b = (i % 6 == 0) ? 3'h0 : 3'(i % 6 + 1);
			wb(1'b1, 8'h1c, {29'h0, b});
			wb(1'b0, 8'h1c, 32'h0000_0000);
			chk(rd[10:0], {b, (b == 3'h0) ? mi : w[(b - 3'h2) * 8 +: 8]});
		end
		// Corners: numbers between the ranges name no point, block 7 does not exist
		wb(1'b1, 8'h14, {16'hffff, 6'h00, 2'h1, 2'h0, 6'h0c});
		chk({mo, eo}, {em, ee});
		wb(1'b1, 8'h18, 32'h0000_000c);
		wb(1'b0, 8'h18, 32'h0000_0000);
		chk(rd, 32'h0000_0c00);
		wb(1'b1, 8'h1c, 32'h0000_0007);
		wb(1'b0, 8'h1c, 32'h0000_0000);
		chk(rd, 32'h0000_0700);
		wb(1'b1, 8'h20, 32'h0000_0001);
		{sm, se, sd} = {em, ee, ed};
		wb(1'b1, 8'h04, {24'h0, ~em});
		i_reset <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		chk({mo, eo}, {sm, se});
		chk(oe, ox(sd));
		wb(1'b0, 8'h20, 32'h0000_0000);
		chk(rd[0], 1'b1);
		complete_run();
	end
endmodule // testbench
bind xiob_port xiob_port_assertions u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
	.o_wb_ack(o_wb_ack), .o_main_out(o_main_out), .o_ext_out(o_ext_out), .o_ext_oe_n(o_ext_oe_n));
`default_nettype wire
